// file: core/rffc_defines.vh
/*
 Constants of the receive frame FIFO controller: buffer sizes, register
 offsets, configuration fields, status word layout and chunk sizes.
 Assumes inclusion by bare name from the controller source.
*/
`ifndef RFFC_DEFINES_VH
`define RFFC_DEFINES_VH

// Buffer memory split, in bytes
`define RFFC_SRAM_BYTES 28672
`define RFFC_RXQ_BYTES 20480
`define RFFC_TXQ_BYTES 8192
// Receive queue depth in 32-bit words and pointer width
`define RFFC_RXQ_WORDS 13'd5120
`define RFFC_PTR_W 13

// Register offsets on the plain register port
`define RFFC_REG_HWCFG 4'h0
`define RFFC_REG_OVFCNT 4'h4
`define RFFC_REG_LEVEL 4'h8

// Hardware configuration register fields
`define RFFC_CFG_OFF_LO 0
`define RFFC_CFG_OFF_HI 1
`define RFFC_CFG_DISCARD 2
`define RFFC_CFG_HISPEED 3
`define RFFC_CFG_RESET 4'h0

// Status word fields
`define RFFC_ST_FILTFAIL 30
`define RFFC_ST_LEN_HI 29
`define RFFC_ST_LEN_LO 16
`define RFFC_ST_ERRSUM 15
`define RFFC_ST_BCAST 13
`define RFFC_ST_RUNT 11
`define RFFC_ST_TOOLONG 7
`define RFFC_ST_LATECOL 6
`define RFFC_ST_CRC 1
// Bits passed through from the MAC status; reserved and derived bits are zeroed
`define RFFC_ST_PASS_MASK 32'h40003c7c

// Frame length limits
`define RFFC_MAX_FRAME_BYTES 14'd1518
`define RFFC_LEN_SAT 14'h3fff

// Bulk-in chunk sizes in bytes and in words
`define RFFC_CHUNK_HS_BYTES 512
`define RFFC_CHUNK_FS_BYTES 64
`define RFFC_CHUNK_HS_WORDS 13'd128
`define RFFC_CHUNK_FS_WORDS 13'd16

`endif

// file: core/rffc_rx_fifo.v
/*
 Receive side of the FIFO controller: packs MAC receive bytes into a word
 queue with a status slot ahead of each frame, drops errored or overflowing
 frames by rewinding, and serves committed words to the USB bulk-in engine.
 Assumes one clock, a MAC that leaves at least one idle cycle after each
 status transfer, and bulk-in reads that are single-cycle strobes.
*/
`timescale 1ns/1ns
`include "rffc_defines.vh"

// Behaviour
// - One 28 KB buffer: 20 KB receive queue here, 8 KB transmit queue elsewhere.
// - Queue data offered to bulk-in engine in 512-byte or 64-byte chunks.
// - Write pointer advances as each received word is stored.
// - Head pointer marks slot before frame data; status written there at completion.
// - Zero to three pad bytes inserted before frame data, from offset field.
// - Frame stays hidden from bulk-in engine until data and status committed.
// - With discard enabled, CRC, late collision, oversize or runt frames dropped.
// - Frame dropped when queue fills during its writing.
// - Overflow events counted in a running counter.
// - Write drop loads write pointer from head pointer.
// - Read rewind loads read pointer from read head pointer.
// - After overflow drop, rest of frame ignored until next frame starts.
// - Bulk-in engine may rewind reads to resend a failed packet.
// - Status bit 30 set when address filtering failed.
// - Status bits 29:16 carry frame size in bytes.
// - Status bit 15 is OR of bits 11, 7, 6 and 1.
// - Status bit 13 set for broadcast destination.
// - Status bit 7 flags frames over 1518 bytes, frame kept whole unless discard enabled.
// - Status bit 1 is CRC error or receive error seen during frame.
module rffc_rx_fifo #(
   parameter PW = `RFFC_PTR_W
) (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // MAC receive interface
   input wire mac_rx_byte_valid,
   input wire [7:0] mac_rx_byte,
   input wire mac_rx_status_valid,
   input wire [31:0] mac_rx_status,
   input wire receive_error_input,
   // USB bulk-in engine
   input wire usb_rd_req,
   input wire usb_rd_ack,
   input wire usb_rd_rewind,
   output reg [31:0] usb_rd_data_r,
   output reg usb_rd_valid_r,
   output reg [PW-1:0] usb_avail_words_r,
   output reg usb_chunk_ready_r,
   // Register port
   input wire [3:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata_r,
   // Overflow event count
   output reg [31:0] overflow_count_r
);

   // Write-side states
   localparam ST_IDLE = 4'b0001;
   localparam ST_FRAME = 4'b0010;
   localparam ST_DISCARD = 4'b0100;
   localparam ST_COMMIT = 4'b1000;

   // Next slot with wrap at queue depth
   function [PW-1:0] ptr_inc;
      input [PW-1:0] p;
      begin
         if (p == `RFFC_RXQ_WORDS - 13'd1) begin
            ptr_inc = {PW{1'b0}};
         end else begin
            ptr_inc = p + 13'd1;
         end
      end
   endfunction

   // Words from b up to a, modulo queue depth
   function [PW-1:0] ptr_diff;
      input [PW-1:0] a;
      input [PW-1:0] b;
      begin
         if (a >= b) begin
            ptr_diff = a - b;
         end else begin
            ptr_diff = a + `RFFC_RXQ_WORDS - b;
         end
      end
   endfunction

   // Receive queue storage, 20 KB of words
   reg [31:0] mem [0:`RFFC_RXQ_WORDS-1];

   reg [3:0] state_r, state_nxt;
   reg [PW-1:0] wr_r, wr_nxt;
   reg [PW-1:0] head_r, head_nxt;
   reg [PW-1:0] commit_r, commit_nxt;
   reg [PW-1:0] rd_r, rd_nxt;
   reg [PW-1:0] rd_head_r, rd_head_nxt;
   reg [31:0] buf_r, buf_nxt;
   reg [1:0] lane_r, lane_nxt;
   reg [13:0] len_r, len_nxt;
   reg rxer_r, rxer_nxt;
   reg [31:0] status_r, status_nxt;
   reg drop_r, drop_nxt;
   reg [31:0] ovf_nxt;
   reg [3:0] cfg_r;
   reg mem_we;
   reg [PW-1:0] mem_waddr;
   reg [31:0] mem_wdata;
   reg [PW-1:0] wpos;
   reg [31:0] word_fill;
   reg [13:0] len_fin;
   reg [31:0] st_word;
   reg bad;
   reg rd_take;

   wire [1:0] cfg_offset = cfg_r[`RFFC_CFG_OFF_HI:`RFFC_CFG_OFF_LO];
   wire cfg_discard = cfg_r[`RFFC_CFG_DISCARD];
   wire cfg_hispeed = cfg_r[`RFFC_CFG_HISPEED];
   wire [PW-1:0] avail = ptr_diff(commit_r, rd_r);
   wire [PW-1:0] used = ptr_diff(wr_r, rd_head_r);

   // Write-side sequencing, packing and pointer control
   always @* begin
      state_nxt = state_r;
      wr_nxt = wr_r;
      head_nxt = head_r;
      commit_nxt = commit_r;
      buf_nxt = buf_r;
      lane_nxt = lane_r;
      len_nxt = len_r;
      rxer_nxt = rxer_r | receive_error_input;
      status_nxt = status_r;
      drop_nxt = drop_r;
      ovf_nxt = overflow_count_r;
      mem_we = 1'b0;
      mem_waddr = wr_r;
      mem_wdata = buf_r;
      wpos = wr_r;
      word_fill = buf_r;
      len_fin = len_r;
      st_word = 32'h0;
      bad = 1'b0;
      case (state_r)
         ST_IDLE: begin
            rxer_nxt = 1'b0;
            if (mac_rx_byte_valid) begin
               // First byte opens the frame one slot past its status slot
               wpos = ptr_inc(head_r);
               word_fill = 32'h0;
               word_fill[cfg_offset*8 +: 8] = mac_rx_byte;
               rxer_nxt = receive_error_input;
               len_nxt = 14'd1;
               if (wpos == rd_head_r ||
                   (cfg_offset == 2'd3 && ptr_inc(wpos) == rd_head_r)) begin
                  ovf_nxt = overflow_count_r + 32'h1;
                  wr_nxt = head_r;
                  state_nxt = ST_DISCARD;
               end else if (cfg_offset == 2'd3) begin
                  mem_we = 1'b1;
                  mem_waddr = wpos;
                  mem_wdata = word_fill;
                  wr_nxt = ptr_inc(wpos);
                  buf_nxt = 32'h0;
                  lane_nxt = 2'd0;
                  state_nxt = ST_FRAME;
               end else begin
                  wr_nxt = wpos;
                  buf_nxt = word_fill;
                  lane_nxt = cfg_offset + 2'd1;
                  state_nxt = ST_FRAME;
               end
            end
         end
         ST_FRAME: begin
            if (mac_rx_status_valid) begin
               // Status word composed from MAC flags and own byte count
               st_word = mac_rx_status & `RFFC_ST_PASS_MASK;
               st_word[`RFFC_ST_LEN_HI:`RFFC_ST_LEN_LO] = len_r;
               st_word[`RFFC_ST_TOOLONG] = (len_r > `RFFC_MAX_FRAME_BYTES);
               st_word[`RFFC_ST_CRC] = mac_rx_status[`RFFC_ST_CRC] | rxer_nxt;
               st_word[`RFFC_ST_ERRSUM] = st_word[`RFFC_ST_RUNT] | st_word[`RFFC_ST_TOOLONG] |
                                          st_word[`RFFC_ST_LATECOL] | st_word[`RFFC_ST_CRC];
               bad = st_word[`RFFC_ST_RUNT] | st_word[`RFFC_ST_TOOLONG] |
                     st_word[`RFFC_ST_LATECOL] | st_word[`RFFC_ST_CRC];
               status_nxt = st_word;
               drop_nxt = cfg_discard & bad;
               if (lane_r != 2'd0 && ptr_inc(wr_r) == rd_head_r) begin
                  ovf_nxt = overflow_count_r + 32'h1;
                  wr_nxt = head_r;
                  state_nxt = ST_IDLE;
               end else begin
                  if (lane_r != 2'd0) begin
                     // Flush the partial last word
                     mem_we = 1'b1;
                     wr_nxt = ptr_inc(wr_r);
                  end
                  buf_nxt = 32'h0;
                  lane_nxt = 2'd0;
                  state_nxt = ST_COMMIT;
               end
            end else if (mac_rx_byte_valid) begin
               word_fill[lane_r*8 +: 8] = mac_rx_byte;
               if (len_r != `RFFC_LEN_SAT) begin
                  len_nxt = len_r + 14'd1;
               end
               if (lane_r == 2'd3) begin
                  if (ptr_inc(wr_r) == rd_head_r) begin
                     ovf_nxt = overflow_count_r + 32'h1;
                     wr_nxt = head_r;
                     state_nxt = ST_DISCARD;
                  end else begin
                     mem_we = 1'b1;
                     mem_wdata = word_fill;
                     wr_nxt = ptr_inc(wr_r);
                  end
                  buf_nxt = 32'h0;
               end else begin
                  buf_nxt = word_fill;
               end
               lane_nxt = lane_r + 2'd1;
            end
         end
         ST_DISCARD: begin
            // Remainder of an overflowed frame ignored until its status
            buf_nxt = 32'h0;
            lane_nxt = 2'd0;
            if (mac_rx_status_valid) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_COMMIT: begin
            mem_we = 1'b1;
            mem_waddr = head_r;
            mem_wdata = status_r;
            if (drop_r) begin
               wr_nxt = head_r;
            end else begin
               head_nxt = wr_r;
               commit_nxt = wr_r;
            end
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
            wr_nxt = head_r;
         end
      endcase
   end

   // Read side: fetch, acknowledge and rewind
   always @* begin
      rd_take = usb_rd_req && (rd_r != commit_r);
      rd_nxt = rd_r;
      rd_head_nxt = rd_head_r;
      if (usb_rd_rewind) begin
         rd_nxt = rd_head_r;
      end else if (rd_take) begin
         rd_nxt = ptr_inc(rd_r);
      end
      if (usb_rd_ack && !usb_rd_rewind) begin
         rd_head_nxt = rd_r;
      end
   end

   // Queue memory ports
   always @(posedge clk_sys) begin
      if (mem_we) begin
         mem[mem_waddr] <= mem_wdata;
      end
   end

   // State, pointers and outputs
   always @(posedge clk_sys) begin
      if (rst) begin
         state_r <= ST_IDLE;
         wr_r <= {PW{1'b0}};
         head_r <= {PW{1'b0}};
         commit_r <= {PW{1'b0}};
         rd_r <= {PW{1'b0}};
         rd_head_r <= {PW{1'b0}};
         buf_r <= 32'h0;
         lane_r <= 2'd0;
         len_r <= 14'd0;
         rxer_r <= 1'b0;
         status_r <= 32'h0;
         drop_r <= 1'b0;
         overflow_count_r <= 32'h0;
         usb_rd_data_r <= 32'h0;
         usb_rd_valid_r <= 1'b0;
         usb_avail_words_r <= {PW{1'b0}};
         usb_chunk_ready_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         wr_r <= wr_nxt;
         head_r <= head_nxt;
         commit_r <= commit_nxt;
         rd_r <= rd_nxt;
         rd_head_r <= rd_head_nxt;
         buf_r <= buf_nxt;
         lane_r <= lane_nxt;
         len_r <= len_nxt;
         rxer_r <= rxer_nxt;
         status_r <= status_nxt;
         drop_r <= drop_nxt;
         overflow_count_r <= ovf_nxt;
         usb_rd_valid_r <= rd_take;
         if (rd_take) begin
            usb_rd_data_r <= mem[rd_r];
         end
         usb_avail_words_r <= avail;
         // Chunk size follows USB speed
         if (cfg_hispeed) begin
            usb_chunk_ready_r <= (avail >= `RFFC_CHUNK_HS_WORDS);
         end else begin
            usb_chunk_ready_r <= (avail >= `RFFC_CHUNK_FS_WORDS);
         end
      end
   end

   // Register port: configuration write, registered read
   always @(posedge clk_sys) begin
      if (rst) begin
         cfg_r <= `RFFC_CFG_RESET;
         reg_rdata_r <= 32'h0;
      end else begin
         if (reg_wr && reg_addr == `RFFC_REG_HWCFG) begin
            cfg_r <= reg_wdata[`RFFC_CFG_HISPEED:`RFFC_CFG_OFF_LO];
         end
         reg_rdata_r <= 32'h0;
         if (reg_rd) begin
            case (reg_addr)
               `RFFC_REG_HWCFG: reg_rdata_r <= {28'h0, cfg_r};
               `RFFC_REG_OVFCNT: reg_rdata_r <= overflow_count_r;
               `RFFC_REG_LEVEL: reg_rdata_r <= {19'h0, used};
               default: reg_rdata_r <= 32'h0;
            endcase
         end
      end
   end

endmodule

// file: tb/rffc_rx_fifo_properties.sv
/*
 Port timing checks for the receive frame FIFO controller.
 Assumes binding to every rffc_rx_fifo instance, one clock domain.
*/
`timescale 1ns/1ns
`include "rffc_defines.vh"
module rffc_rx_fifo_chk #(
   parameter PW = 13
) (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Watched inputs
   input wire mac_rx_byte_valid,
   input wire mac_rx_status_valid,
   input wire usb_rd_req,
   input wire [3:0] reg_addr,
   input wire reg_rd,
   // Watched outputs
   input wire usb_rd_valid_r,
   input wire [PW-1:0] usb_avail_words_r,
   input wire usb_chunk_ready_r,
   input wire [31:0] reg_rdata_r,
   input wire [31:0] overflow_count_r
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Bulk-in read answers
   rd_after_req_a: assert property (usb_rd_valid_r |-> $past(usb_rd_req))
      else $error("read valid without request");
   rd_served_a: assert property ($past(usb_rd_req) && $past(usb_avail_words_r) > 1 |-> usb_rd_valid_r)
      else $error("read request not served");
   avail_dec_a: assert property (usb_avail_words_r < $past(usb_avail_words_r)
      |-> $past(usb_avail_words_r) - usb_avail_words_r == 1) else $error("available words fell by more than one");
   chunk_level_a: assert property (usb_chunk_ready_r
      |-> usb_avail_words_r >= 16) else $error("chunk ready below chunk size");
   // Register port and overflow counter
   reg_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_r == 32'h0)
      else $error("read data outside read answer cycle");
   reg_count_a: assert property ($past(reg_rd) && $past(reg_addr) == `RFFC_REG_OVFCNT
      && $stable(overflow_count_r) |-> reg_rdata_r == overflow_count_r) else $error("overflow count read wrong");
   ovf_step_a: assert property ($changed(overflow_count_r)
      |-> overflow_count_r == $past(overflow_count_r) + 32'h1) else $error("overflow count step not one");
   ovf_cause_a: assert property ($changed(overflow_count_r) |-> $past(mac_rx_byte_valid)
      || $past(mac_rx_status_valid) || $past(mac_rx_byte_valid, 2) || $past(mac_rx_status_valid, 2))
      else $error("overflow counted without receive traffic");
   // Main scenarios reached
   cover property (usb_rd_valid_r);
   cover property ($changed(overflow_count_r));
   cover property (usb_chunk_ready_r);
endmodule
bind rffc_rx_fifo rffc_rx_fifo_chk #(.PW(PW)) u_rffc_rx_fifo_chk (.clk_sys(clk_sys), .rst(rst),
   .mac_rx_byte_valid(mac_rx_byte_valid), .mac_rx_status_valid(mac_rx_status_valid), .usb_rd_req(usb_rd_req),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .usb_rd_valid_r(usb_rd_valid_r), .usb_avail_words_r(usb_avail_words_r),
   .usb_chunk_ready_r(usb_chunk_ready_r), .reg_rdata_r(reg_rdata_r), .overflow_count_r(overflow_count_r));

// file: tb/rffc_mac_model.sv
/*
 MAC receive side model: streams frame bytes, then the status word.
 Assumes send_frame is called from one process at a time.
*/
`timescale 1ns/1ns
module rffc_mac_model (
   // Clock
   input wire clk_sys,
   // Receive stream
   output reg mac_rx_byte_valid,
   output reg [7:0] mac_rx_byte,
   output reg mac_rx_status_valid,
   output reg [31:0] mac_rx_status,
   output reg receive_error_input
);
   // Idle at time zero
   initial begin
      mac_rx_byte_valid = 1'b0;
      mac_rx_byte = 8'h5a;
      mac_rx_status_valid = 1'b0;
      mac_rx_status = 32'ha5a5_a5a5;
      receive_error_input = 1'b0;
   end
   // Frame bytes with gap idle cycles between, status last, then idle
   task send_frame(input integer n, input integer gap, input [31:0] st, input err);
      integer i, g, b;
      begin
         for (i = 0; i < n; i = i + 1) begin
            for (g = 0; g < gap; g = g + 1) begin
               @(posedge clk_sys);
               mac_rx_byte_valid <= 1'b0;
               mac_rx_byte <= ~mac_rx_byte;
            end
            b = i * 3 + 1;
            @(posedge clk_sys);
            mac_rx_byte_valid <= 1'b1;
            mac_rx_byte <= b[7:0];
            receive_error_input <= err;
         end
         @(posedge clk_sys);
         mac_rx_byte_valid <= 1'b0;
         mac_rx_byte <= ~mac_rx_byte;
         mac_rx_status_valid <= 1'b1;
         mac_rx_status <= st;
         @(posedge clk_sys);
         mac_rx_status_valid <= 1'b0;
         mac_rx_status <= ~st;
         receive_error_input <= 1'b0;
         @(posedge clk_sys);
         mac_rx_byte <= ~mac_rx_byte;
      end
   endtask
endmodule

// file: tb/tb.sv
/*
 Bench for rffc_rx_fifo: register port and bulk-in reads by tasks.
 Assumes the MAC model supplies frames; 250 MHz clock.
*/
`timescale 1ns/1ns
`include "rffc_defines.vh"
module tb;
   reg clk_sys, rst, usb_rd_req, usb_rd_ack, usb_rd_rewind, reg_wr, reg_rd, hs;
   reg [3:0] reg_addr;
   reg [31:0] reg_wdata, d;
   wire [31:0] usb_rd_data_r, reg_rdata_r, overflow_count_r, mac_rx_status;
   wire [12:0] usb_avail_words_r;
   wire [7:0] mac_rx_byte;
   wire mac_rx_byte_valid, mac_rx_status_valid, receive_error_input, usb_rd_valid_r, usb_chunk_ready_r;
   integer failures, samples_checked, i, k;
   // Design and far side
   rffc_rx_fifo u_rffc_rx_fifo (.clk_sys(clk_sys), .rst(rst), .mac_rx_byte_valid(mac_rx_byte_valid),
      .mac_rx_byte(mac_rx_byte), .mac_rx_status_valid(mac_rx_status_valid), .mac_rx_status(mac_rx_status),
      .receive_error_input(receive_error_input), .usb_rd_req(usb_rd_req), .usb_rd_ack(usb_rd_ack),
      .usb_rd_rewind(usb_rd_rewind), .usb_rd_data_r(usb_rd_data_r), .usb_rd_valid_r(usb_rd_valid_r),
      .usb_avail_words_r(usb_avail_words_r), .usb_chunk_ready_r(usb_chunk_ready_r), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
      .overflow_count_r(overflow_count_r));
   rffc_mac_model u_rffc_mac_model (.clk_sys(clk_sys), .mac_rx_byte_valid(mac_rx_byte_valid),
      .mac_rx_byte(mac_rx_byte), .mac_rx_status_valid(mac_rx_status_valid), .mac_rx_status(mac_rx_status),
      .receive_error_input(receive_error_input));
   // Clock
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   task summarize;
      begin
         $display("checked %0d mismatches %0d", samples_checked, failures);
         if (failures == 0 && samples_checked > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task check(input [31:0] got, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task reg_write(input [3:0] a, input [31:0] v);
      begin
         @(posedge clk_sys);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= v;
         @(posedge clk_sys);
         reg_wr <= 1'b0;
      end
   endtask
   task reg_read(input [3:0] a);
      begin
         @(posedge clk_sys);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge clk_sys);
         reg_rd <= 1'b0;
         #1 d = reg_rdata_r;
      end
   endtask
   // One word from the bulk-in side, answer one cycle later
   task usb_read(input [31:0] exp);
      begin
         @(posedge clk_sys);
         usb_rd_req <= 1'b1;
         @(posedge clk_sys);
         usb_rd_req <= 1'b0;
         #1 check(usb_rd_valid_r, 32'h1);
         check(usb_rd_data_r, exp);
      end
   endtask
   // Packet accepted (0) or resend (1)
   task usb_pulse(input sel);
      begin
         @(posedge clk_sys);
         usb_rd_ack <= !sel;
         usb_rd_rewind <= sel;
         @(posedge clk_sys);
         usb_rd_ack <= 1'b0;
         usb_rd_rewind <= 1'b0;
      end
   endtask
   task wait_avail(input [12:0] n);
      integer t;
      begin
         t = 0;
         #1;
         while (usb_avail_words_r !== n && t < 100) begin
            @(posedge clk_sys);
            #1 t = t + 1;
         end
         check(usb_avail_words_r, n);
         if (usb_avail_words_r !== n)
            summarize;
      end
   endtask
   function [31:0] exp_word(input integer k, input integer off, input integer n);
      integer j, p, b;
      begin
         exp_word = 32'h0;
         for (j = 0; j < 4; j = j + 1) begin
            p = k * 4 + j - off;
            b = p * 3 + 1;
            if (p >= 0 && p < n)
               exp_word[j*8 +: 8] = b[7:0];
         end
      end
   endfunction
   function [31:0] exp_st(input [31:0] st, input integer n, input err);
      begin
         exp_st = st & `RFFC_ST_PASS_MASK;
         exp_st[29:16] = n[13:0];
         exp_st[1] = st[1] | err;
         exp_st[7] = n > 1518;
         exp_st[15] = exp_st[11] | exp_st[7] | exp_st[6] | exp_st[1];
      end
   endfunction
   // Send a frame, then read it back whole and accept it
   task frame(input integer n, input integer off, input [31:0] st, input err);
      integer w;
      begin
         w = (n + off + 3) / 4;
         u_rffc_mac_model.send_frame(n, off & 1, st, err);
         wait_avail(w + 1);
         @(posedge clk_sys);
         #1 check(usb_chunk_ready_r, (w + 1) >= (hs ? 128 : 16));
         reg_read(`RFFC_REG_LEVEL);
         check(d, w + 1);
         usb_read(exp_st(st, n, err));
         for (k = 0; k < w; k = k + 1)
            usb_read(exp_word(k, off, n));
         usb_pulse(1'b0);
      end
   endtask
   // Main sequence
   initial begin
      rst = 1'b1;
      usb_rd_req = 1'b0;
      usb_rd_ack = 1'b0;
      usb_rd_rewind = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      hs = 1'b0;
      failures = 0;
      samples_checked = 0;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      reg_write(`RFFC_REG_OVFCNT, 32'hffff_ffff);
      for (i = 0; i < 16; i = i + 4) begin
         reg_read(i[3:0]);
         check(d, 32'h0);
      end
      $display("test registers done");
      frame(5, 0, 32'hc000_2041, 1'b0);
      for (i = 1; i < 4; i = i + 1) begin
         reg_write(`RFFC_REG_HWCFG, i);
         frame(6, i, 32'h0, i == 2);
      end
      $display("test offsets done");
      reg_write(`RFFC_REG_HWCFG, 32'h4);
      reg_read(`RFFC_REG_HWCFG);
      check(d, 32'h4);
      for (i = 0; i < 4; i = i + 1) begin
         u_rffc_mac_model.send_frame(8, 0, (i == 0) ? 32'h2 : (i == 1) ? 32'h40 :
            (i == 2) ? 32'h800 : 32'h0, i == 3);
         repeat (4) @(posedge clk_sys);
         #1 check(usb_avail_words_r, 32'h0);
      end
      frame(4, 0, 32'h0, 1'b0);
      $display("test discard done");
      reg_write(`RFFC_REG_HWCFG, 32'h0);
      u_rffc_mac_model.send_frame(8, 0, 32'h0, 1'b0);
      wait_avail(3);
      usb_read(exp_st(32'h0, 8, 1'b0));
      usb_pulse(1'b1);
      usb_read(exp_st(32'h0, 8, 1'b0));
      usb_pulse(1'b0);
      usb_read(exp_word(0, 0, 8));
      usb_read(exp_word(1, 0, 8));
      usb_pulse(1'b1);
      usb_read(exp_word(0, 0, 8));
      usb_read(exp_word(1, 0, 8));
      usb_pulse(1'b0);
      wait_avail(0);
      // Request with nothing committed gets no answer
      @(posedge clk_sys);
      usb_rd_req <= 1'b1;
      @(posedge clk_sys);
      usb_rd_req <= 1'b0;
      #1 check(usb_rd_valid_r, 32'h0);
      $display("test rewind done");
      reg_write(`RFFC_REG_HWCFG, 32'h8);
      hs = 1'b1;
      for (i = 1518; i < 1520; i = i + 1)
         frame(i, 0, 32'h0, 1'b0);
      $display("test long frames done");
      reg_write(`RFFC_REG_HWCFG, 32'h0);
      hs = 1'b0;
      u_rffc_mac_model.send_frame(21000, 0, 32'h0, 1'b0);
      repeat (4) @(posedge clk_sys);
      #1 check(overflow_count_r, 32'h1);
      check(usb_avail_words_r, 32'h0);
      reg_read(`RFFC_REG_OVFCNT);
      check(d, 32'h1);
      frame(4, 0, 32'h0, 1'b0);
      $display("test overflow done");
      summarize;
   end
endmodule
